// ### include/sfsr_pkg.sv
// Constants for the serial flash status register block.
// Assumes a 20 MHz reference clock and SPI modes 0 and 3 on the pins.
package sfsr_pkg;

    // Opcodes
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_ONE     = 8'h05;
    localparam logic [7:0] OP_READ_TWO     = 8'h35;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_VOL_ENABLE   = 8'h50;

    // Byte one fields
    localparam int B1_MODE_LO = 7;
    localparam int B1_SIZE    = 6;
    localparam int B1_TB      = 5;
    localparam int B1_BP2     = 4;
    localparam int B1_BP0     = 2;
    localparam int B1_WEL     = 1;
    localparam int B1_BUSY    = 0;

    // Byte two fields
    localparam int B2_SUSP    = 7;
    localparam int B2_CMP     = 6;
    localparam int B2_LOCK_C  = 5;
    localparam int B2_LOCK_A  = 3;
    localparam int B2_RSVD    = 2;
    localparam int B2_QE      = 1;
    localparam int B2_MODE_HI = 0;

    // Writable bits of each byte
    localparam logic [7:0] B1_WR_MASK = 8'hFC;
    localparam logic [7:0] B2_WR_MASK = 8'h7B;

    // Factory contents of the non-volatile bits
    localparam logic [7:0] NV_DEFAULT_ONE = 8'h00;
    localparam logic [7:0] NV_DEFAULT_TWO = 8'h00;

    // Protection modes, {mode_hi, mode_lo}
    localparam logic [1:0] MODE_SOFT     = 2'h0;
    localparam logic [1:0] MODE_HW       = 2'h1;
    localparam logic [1:0] MODE_LOCKDOWN = 2'h2;
    localparam logic [1:0] MODE_OTP      = 2'h3;

    // Bit counter and data byte counter
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [1:0] DATA_NONE = 2'h0;
    localparam logic [1:0] DATA_ONE  = 2'h1;
    localparam logic [1:0] DATA_TWO  = 2'h2;

    // Timing
    localparam int REF_CLK_KHZ  = 20000;
    localparam int NV_COMMIT_US = 10;
    localparam int NV_COMMIT_CYCLES = NV_COMMIT_US * REF_CLK_KHZ / 1000;

    typedef enum logic [3:0] {
        ST_OPCODE = 4'h1,
        ST_DATA   = 4'h2,
        ST_READ   = 4'h4,
        ST_IGNORE = 4'h8
    } state_t;

endpackage

// ### core/serial_flash_status_register.sv
// Status register bank of a serial flash: opcode decode, status
// read and write, write-enable latch, protection and busy flag.
// Assumes pins from outside the clock domain and SCK well below
// a quarter of the reference clock.
// Overview of operation
// - Modes 00: status write accepted only with latch set, pin ignored.
// - Modes 01: write-protect pin low rejects writes unless quad enable is set; high allows them.
// - Modes 10: writes blocked until power cycle, which returns 00.
// - Modes 11: status permanently locked, every write refused.
// - Size, top/bottom, block bits set region; complement inverts it.
// - Latch clear refuses program, erase, page and status writes.
// - Latch is 0 after power-up or reset.
// - Latch clears when qualifying write commands complete or abort.
// - Incomplete or unknown opcode abort leaves the latch set.
// - Suspend flag at byte two bit 7, read-only.
// - Three page lock bits at byte two bits 5..3, default 0.
// - Quad enable turns hold and protect pins into data pins.
// - Data byte layouts for byte one and byte two.
// - Valid status write commits at chip-select release, clears latch.
// - Short or misaligned write aborts, bits kept, latch cleared.
// - Byte two writable bits 6..3, 1, 0; bit 2 reads 0.
// - Power-up copies non-volatile bits into governing working copy.
// - 50h leaves latch alone, covers a status write only when it is the next command.
// - 05h reads byte one, 35h byte two, repeating from bit 7.
// - Status reads allowed at any time, even while busy.
// - Byte one: latch bit 1, busy bit 0, only 7..2 writable.
module serial_flash_status_register
    import sfsr_pkg::*;
#(
    parameter logic [7:0]  OP_WRITE_DISABLE = 8'h04,
    parameter logic [7:0]  NV_INIT_ONE      = NV_DEFAULT_ONE,
    parameter logic [7:0]  NV_INIT_TWO      = NV_DEFAULT_TWO,
    parameter int unsigned COMMIT_CYCLES    = NV_COMMIT_CYCLES
)(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    // Serial pins
    input  wire logic       i_cs_b,
    input  wire logic       i_sck,
    input  wire logic       i_si,
    input  wire logic       i_wp_b,
    output logic            o_so,
    output logic            o_so_oe,
    // Rest of the device
    input  wire logic       i_array_busy,
    input  wire logic       i_erase_suspended,
    input  wire logic       i_wel_clear,
    output logic            o_wel,
    output logic            o_busy,
    output logic [5:0]      o_protect_region,
    output logic [2:0]      o_page_lock,
    output logic            o_quad_enable
);

    localparam int CW = $clog2(COMMIT_CYCLES + 1);
    localparam logic [CW-1:0] COMMIT_LOAD = CW'(COMMIT_CYCLES);
    localparam logic [CW-1:0] COUNT_ZERO  = '0;

    function automatic logic [7:0] merge(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Pin synchronisers: cs, sck, si, wp
    logic [3:0]  sync1_q;
    logic [3:0]  sync2_q;
    logic        cs_p_q;
    logic        sck_p_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
            cs_p_q  <= 1'b1;
            sck_p_q <= 1'b0;
        end else begin
            sync1_q <= {i_wp_b, i_si, i_sck, i_cs_b};
            sync2_q <= sync1_q;
            cs_p_q  <= sync2_q[0];
            sck_p_q <= sync2_q[1];
        end
    end

    wire cs_s     = sync2_q[0];
    wire sck_s    = sync2_q[1];
    wire si_s     = sync2_q[2];
    wire wp_s     = sync2_q[3];
    wire cs_act   = ~cs_s;
    wire cs_idle  = cs_s & cs_p_q;
    wire cs_rel   = cs_s & ~cs_p_q;
    wire sck_rise = cs_act & sck_s & ~sck_p_q;
    wire sck_fall = cs_act & ~sck_s & sck_p_q;

    // Serial engine state
    state_t      state_q;
    state_t      state_d;
    logic [7:0]  shift_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  op_q;
    logic        op_full_q;
    logic [1:0]  data_cnt_q;
    logic [7:0]  data1_q;
    logic [7:0]  data2_q;
    logic [2:0]  rd_idx_q;
    logic        so_q;
    logic        so_oe_q;

    // Status storage; the stored pair keeps its contents through
    // reset, which stands for a power cycle
    logic [7:0]  nv1_q = NV_INIT_ONE;
    logic [7:0]  nv2_q = NV_INIT_TWO;
    logic [7:0]  vol1_q;
    logic [7:0]  vol2_q;
    logic        load_q;
    logic        wel_q;
    logic        wel_d;
    logic        vol_arm_q;
    logic        vol_arm_d;
    logic [CW-1:0] commit_q;
    logic        busy_q;

    wire [7:0] shifted   = {shift_q[6:0], si_s};
    wire       byte_done = sck_rise & (bit_cnt_q == BIT_LAST);
    wire       aligned   = bit_cnt_q == BIT_FIRST;
    wire       op_byte   = byte_done & (state_q == ST_OPCODE);
    wire       is_wrsr   = shifted == OP_WRITE_STATUS;
    wire       is_read   = (shifted == OP_READ_ONE) |
                           (shifted == OP_READ_TWO);

    always_comb begin
        state_d = state_q;
        if (!cs_act) begin
            state_d = ST_OPCODE;
        end else begin
            unique case (state_q)
                ST_OPCODE: begin
                    if (byte_done) begin
                        state_d = is_wrsr ? ST_DATA :
                                  is_read ? ST_READ : ST_IGNORE;
                    end
                end
                ST_DATA:   state_d = ST_DATA;
                ST_READ:   state_d = ST_READ;
                ST_IGNORE: state_d = ST_IGNORE;
                default:   state_d = ST_OPCODE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q   <= ST_OPCODE;
            shift_q   <= 8'h00;
            bit_cnt_q <= BIT_FIRST;
            op_q      <= 8'h00;
            op_full_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (cs_idle) begin
                bit_cnt_q <= BIT_FIRST;
                op_full_q <= 1'b0;
            end else if (sck_rise) begin
                shift_q   <= shifted;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (op_byte) begin
                op_q      <= shifted;
                op_full_q <= 1'b1;
            end
        end
    end

    // Data bytes of a status write; bytes past the second are dropped
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_cnt_q <= DATA_NONE;
            data1_q    <= 8'h00;
            data2_q    <= 8'h00;
        end else if (cs_idle) begin
            data_cnt_q <= DATA_NONE;
        end else if (byte_done && state_q == ST_DATA) begin
            if (data_cnt_q == DATA_NONE) begin
                data1_q    <= shifted;
                data_cnt_q <= DATA_ONE;
            end else if (data_cnt_q == DATA_ONE) begin
                data2_q    <= shifted;
                data_cnt_q <= DATA_TWO;
            end
        end
    end

    // Live status bytes; busy and suspend are never stored
    wire [7:0] byte_one = {vol1_q[B1_MODE_LO:B1_BP0],
                           wel_q, busy_q};
    wire [7:0] byte_two = {i_erase_suspended,
                           vol2_q[B2_CMP:B2_LOCK_A], 1'b0,
                           vol2_q[B2_QE:B2_MODE_HI]};
    wire [7:0] rd_byte  = (op_q == OP_READ_TWO) ? byte_two : byte_one;

    // Read path shifts on the falling edge, never gated by busy
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_idx_q <= BIT_LAST;
            so_q     <= 1'b0;
            so_oe_q  <= 1'b0;
        end else begin
            so_oe_q <= state_d == ST_READ;
            if (op_byte) begin
                rd_idx_q <= BIT_LAST;
            end else if (sck_fall && state_q == ST_READ) begin
                so_q     <= rd_byte[rd_idx_q];
                rd_idx_q <= rd_idx_q - 3'h1;
            end
        end
    end

    // Protection decode on the working copy
    wire [1:0] mode   = {vol2_q[B2_MODE_HI], vol1_q[B1_MODE_LO]};
    // In quad mode the protect pin carries data, so it cannot guard
    wire       wp_eff = wp_s | vol2_q[B2_QE];
    wire       prot_ok = (mode == MODE_SOFT) |
                         ((mode == MODE_HW) & wp_eff);

    // Release events
    wire rel_op    = cs_rel & op_full_q;
    wire wren_ev   = rel_op & aligned & (op_q == OP_WRITE_ENABLE);
    wire wrdi_ev   = rel_op & aligned & (op_q == OP_WRITE_DISABLE);
    wire vol_ev    = rel_op & aligned & (op_q == OP_VOL_ENABLE);
    wire wrsr_seen = rel_op & (op_q == OP_WRITE_STATUS);
    wire wrsr_ok   = wrsr_seen & aligned & (data_cnt_q != DATA_NONE) &
                     wel_q & ~busy_q & prot_ok;
    wire [7:0] new1 = merge(vol1_q, data1_q, B1_WR_MASK);
    wire [7:0] new2 = (data_cnt_q == DATA_TWO) ?
                      merge(vol2_q, data2_q, B2_WR_MASK) : vol2_q;
    wire       nv_write = wrsr_ok & ~vol_arm_q;

    // Set wins over a same-cycle clear
    assign wel_d = wren_ev ? 1'b1 :
                   (wrsr_seen | wrdi_ev | i_wel_clear) ? 1'b0 :
                   wel_q;
    assign vol_arm_d = vol_ev ? 1'b1 :
                       rel_op ? 1'b0 : vol_arm_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wel_q     <= 1'b0;
            vol_arm_q <= 1'b0;
        end else begin
            wel_q     <= wel_d;
            vol_arm_q <= vol_arm_d;
        end
    end

    // Power-up copy; lockdown mode does not survive a power cycle
    wire       lockdown = {nv2_q[B2_MODE_HI], nv1_q[B1_MODE_LO]} ==
                          MODE_LOCKDOWN;
    wire [7:0] up1 = lockdown ? (nv1_q & ~(8'h01 << B1_MODE_LO)) : nv1_q;
    wire [7:0] up2 = lockdown ? (nv2_q & ~(8'h01 << B2_MODE_HI)) : nv2_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            load_q <= 1'b1;
            vol1_q <= 8'h00;
            vol2_q <= 8'h00;
        end else if (load_q) begin
            load_q <= 1'b0;
            vol1_q <= up1;
            vol2_q <= up2;
        end else if (wrsr_ok) begin
            vol1_q <= new1;
            vol2_q <= new2;
        end
    end

    // No reset: stored bits must outlive a power cycle
    always_ff @(posedge i_ref_clk) begin
        if (load_q) begin
            nv1_q <= up1;
            nv2_q <= up2;
        end else if (nv_write) begin
            nv1_q <= new1;
            nv2_q <= new2;
        end
    end

    // Non-volatile commit timer drives busy
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            commit_q <= COUNT_ZERO;
            busy_q   <= 1'b0;
        end else begin
            if (nv_write) begin
                commit_q <= COMMIT_LOAD;
            end else if (commit_q != COUNT_ZERO) begin
                commit_q <= commit_q - CW'(1);
            end
            busy_q <= nv_write | (commit_q > CW'(1)) |
                      i_array_busy;
        end
    end

    // Outputs, all straight from flip-flops
    assign o_so          = so_q;
    assign o_so_oe       = so_oe_q;
    assign o_wel         = wel_q;
    assign o_busy        = busy_q;
    assign o_protect_region = {vol2_q[B2_CMP], vol1_q[B1_SIZE],
                               vol1_q[B1_TB],
                               vol1_q[B1_BP2:B1_BP0]};
    assign o_page_lock   = vol2_q[B2_LOCK_C:B2_LOCK_A];
    assign o_quad_enable = vol2_q[B2_QE];

endmodule

// ### tb/sfsr_properties.sv
// Port checks for the serial flash status register bank.
// Assumes one reference clock and the async active-low reset.
module sfsr_properties #(
    parameter int unsigned COMMIT_CYCLES = 4
)(
    input wire logic       i_ref_clk,
    input wire logic       i_rst_b,
    input wire logic       i_cs_b,
    input wire logic       i_array_busy,
    input wire logic       i_wel_clear,
    input wire logic       o_so_oe,
    input wire logic       o_wel,
    input wire logic       o_busy,
    input wire logic [5:0] o_protect_region,
    input wire logic [2:0] o_page_lock,
    input wire logic       o_quad_enable
);
    logic [15:0] run_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // Length of the busy run so far
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b)
            run_q <= 16'h0000;
        else
            run_q <= o_busy ? run_q + 16'h0001 : 16'h0000;
    end
    a_reset_clears: assert property ($rose(i_rst_b) |-> !o_wel && !o_busy)
        else $error("latch or busy set after reset");
    a_clear_pulse: assert property (i_cs_b[*5] ##0 i_wel_clear |=> !o_wel)
        else $error("latch survived a clear pulse");
    a_latch_fall: assert property ($fell(o_wel) |->
        $past(i_wel_clear) || ($past(i_cs_b) && $past(i_cs_b, 2)))
        else $error("latch fell without a cause");
    a_busy_follows: assert property (i_array_busy |-> ##[1:2] o_busy)
        else $error("array activity not shown as busy");
    a_commit_len: assert property ($fell(o_busy) |->
        32'(run_q) == COMMIT_CYCLES || $past(i_array_busy)
        || $past(i_array_busy, 2))
        else $error("commit busy run has wrong length");
    a_commit_clears: assert property ($rose(o_busy) && !i_array_busy
        && !$past(i_array_busy) |-> !o_wel)
        else $error("latch still set when commit starts");
    a_out_quiet: assert property (i_cs_b[*6] |-> !o_so_oe)
        else $error("output driven while deselected");
    a_bits_on_release: assert property (
        !$stable({o_protect_region, o_page_lock, o_quad_enable})
        |-> $past(i_cs_b) && $past(i_cs_b, 2))
        else $error("status bits changed mid-frame");
    c_read: cover property ($rose(o_so_oe));
    c_commit: cover property ($fell(o_busy) && !$past(i_array_busy));
    c_latch: cover property ($rose(o_wel));
endmodule

bind serial_flash_status_register sfsr_properties #(
    .COMMIT_CYCLES(COMMIT_CYCLES)
) u_props (.i_ref_clk, .i_rst_b, .i_cs_b, .i_array_busy, .i_wel_clear,
    .o_so_oe, .o_wel, .o_busy, .o_protect_region, .o_page_lock,
    .o_quad_enable);

// ### tb/spi_host_model.sv
// Mode 0 serial host driving the status register bank's pins.
// Assumes the bench clock; one link bit takes eight of its cycles.
module spi_host_model (
    // Clock
    input  wire logic i_ref_clk,
    // Serial pins
    input  wire logic i_so,
    output logic      o_cs_b,
    output logic      o_sck,
    output logic      o_si
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge i_ref_clk);
        #2;
    endtask
    task automatic bits(input logic [7:0] b, input int n,
                        inout logic [7:0] rd);
        for (int i = 0; i < n; i++) begin
            o_si = b[7-i];
            half();
            o_sck = 1'b1;
            rd = {rd[6:0], i_so};
            half();
            o_sck = 1'b0;
        end
    endtask
    task automatic close();
        half();
        o_cs_b = 1'b1;
        // Released line shows the opposite level, not the old bit
        o_si = ~o_si;
        half();
        half();
    endtask
    // n counts all bits of the frame, opcode included
    task automatic xfer(input logic [7:0] op, input logic [15:0] dat,
                        input int n, output logic [7:0] rd);
        rd = 8'h00;
        half();
        o_cs_b = 1'b0;
        bits(op, (n > 8) ? 8 : n, rd);
        bits(dat[15:8], (n > 16) ? 8 : n - 8, rd);
        bits(dat[7:0], n - 16, rd);
        close();
    endtask
    task automatic poll(output logic [7:0] rd);
        int k;
        k = 0;
        rd = 8'h00;
        half();
        o_cs_b = 1'b0;
        bits(8'h05, 8, rd);
        rd = 8'h01;
        while (rd[0] === 1'b1 && k < 64) begin
            bits(8'h00, 8, rd);
            k++;
        end
        close();
    endtask
endmodule

// ### tb/test_serial_flash_status_register.sv
// Self-checking bench for the status register bank.
// Assumes the host model on the pins and a commit of 4 cycles.
module test_serial_flash_status_register
    import sfsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] ctl;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [4:0] n;
        logic [7:0] e1;
        logic [7:0] e2;
    } row_t;
    // ctl is {write enable first, volatile, protect pin}
    row_t rows [14] = '{
        '{3'h5, 8'h7F, 8'h00, 5'h10, 8'h7C, 8'h00},
        '{3'h5, 8'h00, 8'hFE, 5'h18, 8'h00, 8'h7A},
        '{3'h1, 8'h54, 8'h00, 5'h10, 8'h00, 8'h7A},
        '{3'h5, 8'h54, 8'h00, 5'h14, 8'h00, 8'h7A},
        '{3'h5, 8'h54, 8'h00, 5'h0C, 8'h00, 8'h7A},
        '{3'h7, 8'h24, 8'h38, 5'h18, 8'h24, 8'h38},
        '{3'h5, 8'h80, 8'h00, 5'h18, 8'h80, 8'h00},
        '{3'h4, 8'h84, 8'h00, 5'h10, 8'h80, 8'h00},
        '{3'h5, 8'h88, 8'h02, 5'h18, 8'h88, 8'h02},
        '{3'h4, 8'h8C, 8'h02, 5'h10, 8'h8C, 8'h02},
        '{3'h5, 8'h0C, 8'h03, 5'h18, 8'h0C, 8'h03},
        '{3'h5, 8'h10, 8'h00, 5'h18, 8'h0C, 8'h03},
        '{3'h5, 8'h80, 8'h01, 5'h18, 8'h80, 8'h01},
        '{3'h5, 8'h00, 8'h00, 5'h18, 8'h80, 8'h01}
    };
    // Write-disable opcode handed to the design; no package name exists
    localparam logic [7:0] OP_WR_OFF = 8'h04;
    logic       clk      = 1'b0;
    logic       rst_b    = 1'b0;
    logic       wp_b     = 1'b1;
    logic       arr_busy = 1'b0;
    logic       susp     = 1'b0;
    logic       wel_clr  = 1'b0;
    logic       cs_b, sck, si, so, so_oe, write_enable_latch, busy, qe;
    logic [5:0] region;
    logic [2:0] lock;
    logic [7:0] rd;
    int         err_count = 0;
    int         num_checks = 0;
    always #25 clk = ~clk;
    serial_flash_status_register #(
        .OP_WRITE_DISABLE(OP_WR_OFF),
        .COMMIT_CYCLES(4)
    ) u_dut (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_sck(sck),
        .i_si(si), .i_wp_b(wp_b), .o_so(so), .o_so_oe(so_oe),
        .i_array_busy(arr_busy), .i_erase_suspended(susp),
        .i_wel_clear(wel_clr), .o_wel(write_enable_latch), .o_busy(busy),
        .o_protect_region(region), .o_page_lock(lock), .o_quad_enable(qe));
    spi_host_model u_host (.i_ref_clk(clk), .i_so(so), .o_cs_b(cs_b),
        .o_sck(sck), .o_si(si));
    task automatic chk(input string nm, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (20) @(posedge clk);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #2;
    endtask
    task automatic expect_st(input logic [7:0] e1, e2);
        u_host.xfer(OP_READ_ONE, 16'h0000, 16, rd);
        chk("byte one", {8'h00, e1}, {8'h00, rd});
        u_host.xfer(OP_READ_TWO, 16'h0000, 16, rd);
        chk("byte two", {8'h00, e2}, {8'h00, rd});
        chk("fields", {6'h00, e2[6], e1[6:2], e2[5:3], e2[1]},
            {6'h00, region, lock, qe});
    endtask
    task automatic run_row(input row_t r);
        wp_b = r.ctl[0];
        if (r.ctl[2])
            u_host.xfer(OP_WRITE_ENABLE, 16'h0000, 8, rd);
        if (r.ctl[1])
            u_host.xfer(OP_VOL_ENABLE, 16'h0000, 8, rd);
        u_host.xfer(OP_WRITE_STATUS, {r.d1, r.d2}, int'(r.n), rd);
        u_host.poll(rd);
        expect_st(r.e1, r.e2);
    endtask
    initial begin
        #3000000;
        err_count++;
        print_verdict();
    end
    initial begin
        do_reset();
        chk("latch", 16'h0000, {15'h0000, write_enable_latch});
        expect_st(8'h00, 8'h00);
        for (int i = 0; i < 14; i++) begin
            // Lockdown only lifts on a power cycle
            if (i == 12) begin
                do_reset();
                expect_st(8'h0C, 8'h02);
            end
            run_row(rows[i]);
        end
        u_host.xfer(OP_WRITE_ENABLE, 16'h0000, 8, rd);
        @(posedge clk) #2 wel_clr = 1'b1;
        @(posedge clk) #2 wel_clr = 1'b0;
        repeat (2) @(posedge clk);
        chk("latch", 16'h0000, {15'h0000, write_enable_latch});
        u_host.xfer(OP_WRITE_ENABLE, 16'h0000, 8, rd);
        // Half an opcode, then an unknown one
        u_host.xfer(OP_WRITE_STATUS, 16'h0000, 4, rd);
        u_host.xfer(8'hAB, 16'h0000, 8, rd);
        chk("latch", 16'h0001, {15'h0000, write_enable_latch});
        u_host.xfer(OP_WRITE_STATUS, 16'h0000, 8, rd);
        chk("latch", 16'h0000, {15'h0000, write_enable_latch});
        u_host.xfer(OP_WRITE_ENABLE, 16'h0000, 8, rd);
        u_host.xfer(OP_WR_OFF, 16'h0000, 8, rd);
        chk("latch", 16'h0000, {15'h0000, write_enable_latch});
        u_host.xfer(OP_VOL_ENABLE, 16'h0000, 8, rd);
        chk("latch", 16'h0000, {15'h0000, write_enable_latch});
        arr_busy = 1'b1;
        susp = 1'b1;
        expect_st(8'h81, 8'h81);
        chk("busy", 16'h0001, {15'h0000, busy});
        susp = 1'b0;
        fork
            u_host.poll(rd);
            #15000 arr_busy = 1'b0;
        join
        chk("poll", 16'h0080, {8'h00, rd});
        do_reset();
        expect_st(8'h80, 8'h01);
        print_verdict();
    end
endmodule
